// ### rtl/timer16_pkg.sv
// Purpose: constants for the 16-bit capture/compare timer
// Assumes: AXI4-Lite register access, 32-bit data
// Notes:   offsets are byte addresses
package timer16_pkg;
	localparam int          AddrW        = 8;
	localparam logic [7:0]  OffCtrl      = 8'h00;
	localparam logic [7:0]  OffPrescale  = 8'h04;
	localparam logic [7:0]  OffCapCtrl   = 8'h08;
	localparam logic [7:0]  OffOutCtrl   = 8'h0C;
	localparam logic [7:0]  OffPeriod    = 8'h10;
	localparam logic [7:0]  OffDuty      = 8'h14;
	localparam logic [7:0]  OffCount     = 8'h18;
	localparam logic [7:0]  OffStatus    = 8'h1C;
	// control fields
	localparam int          CtlRunLo     = 0;
	localparam int          CtlRunHi     = 1;
	localparam int          CtlOvf       = 2;
	// prescaler fields
	localparam int          PreSelLo     = 0;
	localparam int          PreSelHi     = 1;
	localparam int          PreEdge0Lo   = 4;
	localparam int          PreEdge0Hi   = 5;
	localparam int          PreEdge1Lo   = 6;
	localparam int          PreEdge1Hi   = 7;
	// capture control fields
	localparam int          CcPeriodCap  = 0;
	localparam int          CcSrcSel     = 1;
	localparam int          CcDutyCap    = 2;
	// output control fields
	localparam int          OcPerInv     = 0;
	localparam int          OcDutyInv    = 1;
	localparam int          OcOneShot    = 2;
	localparam int          OcSwTrig     = 3;
	localparam int          OcOutEn      = 4;
	localparam int          OcMask0      = 5;
	localparam int          OcMaskN      = 6;
	// status fields
	localparam int          StFlag0      = 0;
	localparam int          StFlagN      = 1;
	// run modes
	localparam logic [1:0]  RunStop      = 2'h0;
	localparam logic [1:0]  RunEdgeClr   = 2'h1;
	localparam logic [1:0]  RunFree      = 2'h2;
	localparam logic [1:0]  RunMatchClr  = 2'h3;
	localparam logic [15:0] CountMax     = 16'hFFFF;
	localparam logic [15:0] CountZero    = 16'h0000;
	localparam logic [15:0] CountOne     = 16'h0001;
	localparam int          EventStartN  = 2;
	localparam logic [1:0]  RespOkay     = 2'h0;
	localparam logic [1:0]  RespSlvErr   = 2'h2;
	typedef enum logic [1:0] {OsIdle = 2'b01, OsActive = 2'b10} oneshot_t;
endpackage : timer16_pkg

// ### rtl/timer16_capture_compare.sv
// Purpose: 16-bit timer/event counter with two capture/compare registers
// Assumes: single core clock, synchronous reset, AXI4-Lite slave
// Notes:   count clock is an enable pulse from a prescaler or from the edge input
//
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module timer16_capture_compare
	import timer16_pkg::*;
#(
	parameter int PrescaleW = 8
)(
	// clock and reset
	input  wire logic                      core_clk,
	input  wire logic                      srst,
	// axi4-lite write
	input  wire logic [timer16_pkg::AddrW-1:0] awaddr,
	input  wire logic                      awvalid,
	output logic                           awready,
	input  wire logic [31:0]               wdata,
	input  wire logic [3:0]                wstrb,
	input  wire logic                      wvalid,
	output logic                           wready,
	output logic [1:0]                     bresp,
	output logic                           bvalid,
	input  wire logic                      bready,
	// axi4-lite read
	input  wire logic [timer16_pkg::AddrW-1:0] araddr,
	input  wire logic                      arvalid,
	output logic                           arready,
	output logic [31:0]                    rdata,
	output logic [1:0]                     rresp,
	output logic                           rvalid,
	input  wire logic                      rready,
	// pins
	input  wire logic                      triggerIn0,
	input  wire logic                      sharedPortPinIn,
	output logic                           sharedPortPinOut,
	output logic                           sharedPortPinOeN,
	// events
	output logic                           match0Irq,
	output logic                           matchnIrq
);
	import timer16_pkg::*;

	logic [15:0] mainCounter_q, periodCompareReg_q, dutyCompareReg_q;
	logic [1:0]  runMode_q;
	logic [7:0]  prescalerModeReg_q;
	logic [2:0]  capCtrl_q;
	logic [6:0]  outCtrl_q;
	logic        overflowFlag_q, flag0_q, flagN_q, timerOut_q;
	logic        capPending0_q, capPendingN_q;
	logic [PrescaleW-1:0] preDiv_q;
	logic        tick, tickFall, running, edgeClocked;
	logic [1:0]  sync0_q, sync1_q;
	logic [1:0]  samp0_q, samp1_q;
	logic        lvl0_q, lvl1_q, edge0, edge1;
	logic [1:0]  evCount_q;
	oneshot_t    osState_q;

	function automatic logic edgeValid(input logic [1:0] sel, input logic prev,
		input logic cur);
		edgeValid = (prev != cur) && ((sel == 2'h3) || (sel == 2'h1 && cur)
			|| (sel == 2'h0 && !cur));
	endfunction : edgeValid

	assign running = runMode_q != RunStop;
	assign edgeClocked = prescalerModeReg_q[PreSelHi:PreSelLo] == 2'h3;

	// two-flop synchronisers for the pins
	always_ff @(posedge core_clk)
	begin
		sync0_q <= {sync0_q[0], triggerIn0};
		sync1_q <= {sync1_q[0], sharedPortPinIn};
	end

	// prescaler: tick on rising half, tickFall equal to tick
	always_ff @(posedge core_clk)
	begin
		if (srst || !running)
			preDiv_q <= '0;
		else
			preDiv_q <= preDiv_q + PrescaleW'(1);
	end
	always_comb
	begin
		unique case (prescalerModeReg_q[PreSelHi:PreSelLo])
		2'h0:    tick = running;
		2'h1:    tick = running && (preDiv_q[1:0] == 2'h3);
		2'h2:    tick = running && (preDiv_q == '1);
		default: tick = running && edge0 && (evCount_q == 2'(EventStartN));
		endcase
	end
	assign tickFall = tick;

	// noise filter: two equal samples on core clock if edge-clocked,
	// else on the count tick; stored level survives stop for edge check
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			samp0_q <= 2'h0;
			samp1_q <= 2'h0;
		end
		else if (edgeClocked || tick || !running)
		begin
			samp0_q <= {samp0_q[0], sync0_q[1]};
			samp1_q <= {samp1_q[0], sync1_q[1]};
		end
	end
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			lvl0_q <= 1'b0;
			lvl1_q <= 1'b0;
		end
		else if (running)
		begin
			if (samp0_q[1] == samp0_q[0])
				lvl0_q <= samp0_q[0];
			if (samp1_q[1] == samp1_q[0])
				lvl1_q <= samp1_q[0];
		end
	end
	// level held since stop is compared once counting resumes
	assign edge0 = running && samp0_q[1] == samp0_q[0]
		&& edgeValid(prescalerModeReg_q[PreEdge0Hi:PreEdge0Lo], lvl0_q, samp0_q[0]);
	assign edge1 = running && !outCtrl_q[OcOutEn] && samp1_q[1] == samp1_q[0]
		&& edgeValid(prescalerModeReg_q[PreEdge1Hi:PreEdge1Lo], lvl1_q, samp1_q[0]);

	always_ff @(posedge core_clk)
	begin
		if (srst || !running)
			evCount_q <= 2'h0;
		else if (edgeClocked && edge0 && evCount_q != 2'(EventStartN))
			evCount_q <= evCount_q + 2'h1;
	end

	// axi4-lite slave
	logic        wrFire, rdFire, awHeld_q, wHeld_q;
	logic [7:0]  awAddr_q;
	logic [31:0] wData_q;
	logic        wStrb0_q;
	logic        swTrig;
	assign awready = !awHeld_q && !bvalid;
	assign wready  = !wHeld_q && !bvalid;
	assign wrFire  = (awHeld_q || (awvalid && awready)) && (wHeld_q || (wvalid && wready));
	assign arready = !rvalid;
	assign rdFire  = arvalid && arready;
	logic [7:0]  wAddr;
	logic [31:0] wDat;
	assign wAddr = awHeld_q ? awAddr_q : awaddr;
	assign wDat  = wHeld_q ? wData_q : wdata;
	always_ff @(posedge core_clk)
	begin
		if (srst || wrFire)
		begin
			awHeld_q <= 1'b0;
			wHeld_q  <= 1'b0;
		end
		else
		begin
			if (awvalid && awready)
			begin
				awHeld_q <= 1'b1;
				awAddr_q <= awaddr;
			end
			if (wvalid && wready)
			begin
				wHeld_q <= 1'b1;
				wData_q <= wdata;
				wStrb0_q <= wstrb[0];
			end
		end
	end
	function automatic logic isMapped(input logic [7:0] a);
		isMapped = a[1:0] == 2'h0 && a <= OffStatus;
	endfunction : isMapped
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			bvalid <= 1'b0;
			bresp  <= RespOkay;
		end
		else if (wrFire)
		begin
			bvalid <= 1'b1;
			bresp  <= isMapped(wAddr) ? RespOkay : RespSlvErr;
		end
		else if (bready)
			bvalid <= 1'b0;
	end
	// lane 0 strobe is kept with held write data so an early w beat keeps its mask
	logic wrLane0, wstrbOk;
	assign wstrbOk = wHeld_q ? wStrb0_q : wstrb[0];
	assign wrLane0 = wrFire && wstrbOk;
	assign swTrig = wrLane0 && wAddr == OffOutCtrl && wDat[OcSwTrig];

	// configuration registers; software trigger bit self-clears
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			runMode_q          <= RunStop;
			prescalerModeReg_q <= 8'h00;
			capCtrl_q          <= 3'h0;
			outCtrl_q          <= 7'h00;
		end
		else if (wrLane0)
		begin
			unique case (wAddr)
			OffCtrl:     runMode_q          <= wDat[CtlRunHi:CtlRunLo];
			OffPrescale: prescalerModeReg_q <= wDat[7:0];
			OffCapCtrl:  capCtrl_q          <= wDat[2:0];
			OffOutCtrl:  outCtrl_q          <= {wDat[6:4], 1'b0, wDat[2:0]};
			default:     ;
			endcase
		end
	end

	// matches and one-shot window
	logic match0, matchN, clrStart, cap0, capN, wrap;
	assign match0 = tick && mainCounter_q == periodCompareReg_q;
	assign matchN = tick && mainCounter_q == dutyCompareReg_q;
	assign wrap   = tick && mainCounter_q == CountMax && runMode_q != RunMatchClr;
	assign cap0 = capCtrl_q[CcPeriodCap] && !(capCtrl_q[CcSrcSel]
		&& prescalerModeReg_q[PreEdge0Hi:PreEdge0Lo] == 2'h3)
		&& (capCtrl_q[CcSrcSel] ? 1'b0 : edge1);
	assign capN = capCtrl_q[CcDutyCap] && edge0 && !edgeClocked;
	assign clrStart = (runMode_q == RunEdgeClr && edge0 && !edgeClocked) || swTrig
		|| (outCtrl_q[OcOneShot] && edge0 && osState_q == OsIdle && !edgeClocked);

	// main counter keeps counting through any compare rewrite
	always_ff @(posedge core_clk)
	begin
		if (srst || !running)
			mainCounter_q <= CountZero;
		else if (clrStart)
			mainCounter_q <= CountZero;
		else if (runMode_q == RunMatchClr && match0)
			mainCounter_q <= CountZero;
		else if (tick)
			mainCounter_q <= mainCounter_q + CountOne;
	end

	// compare/capture registers: capture commits on tickFall; its request pends until the next tick
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			periodCompareReg_q <= CountZero;
			dutyCompareReg_q   <= CountZero;
		end
		else
		begin
			if (cap0 && tickFall)
				periodCompareReg_q <= mainCounter_q;
			else if (wrLane0 && wAddr == OffPeriod)
				periodCompareReg_q <= wDat[15:0];
			if (capN && tickFall)
				dutyCompareReg_q <= mainCounter_q;
			else if (wrLane0 && wAddr == OffDuty)
				dutyCompareReg_q <= wDat[15:0];
		end
	end
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			capPending0_q <= 1'b0;
			capPendingN_q <= 1'b0;
		end
		else
		begin
			if (tickFall && (cap0 || (capCtrl_q[CcSrcSel] && edge1)))
				capPending0_q <= 1'b1;
			else if (tick)
				capPending0_q <= 1'b0;
			if (tickFall && capN)
				capPendingN_q <= 1'b1;
			else if (tick)
				capPendingN_q <= 1'b0;
		end
	end

	// request flags: set wins over a software clear
	logic req0, reqN, clr0, clrN, clrOvf;
	assign req0 = (match0 && !capCtrl_q[CcPeriodCap]) || (capPending0_q && tick);
	assign reqN = (matchN && !capCtrl_q[CcDutyCap]) || (capPendingN_q && tick);
	assign clr0 = wrLane0 && wAddr == OffStatus && wDat[StFlag0];
	assign clrN = wrLane0 && wAddr == OffStatus && wDat[StFlagN];
	assign clrOvf = wrLane0 && wAddr == OffCtrl && !wDat[CtlOvf];
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			flag0_q <= 1'b0;
			flagN_q <= 1'b0;
		end
		else
		begin
			flag0_q <= req0 || (flag0_q && !clr0);
			flagN_q <= reqN || (flagN_q && !clrN);
		end
	end
	assign match0Irq = flag0_q && !outCtrl_q[OcMask0];
	assign matchnIrq = flagN_q && !outCtrl_q[OcMaskN];

	// overflow: hold until cleared; a clear while running with count 0000 is refused
	always_ff @(posedge core_clk)
	begin
		if (srst)
			overflowFlag_q <= 1'b0;
		else if (wrap)
			overflowFlag_q <= 1'b1;
		else if (clrOvf && !(running && mainCounter_q == CountZero && overflowFlag_q))
			overflowFlag_q <= 1'b0;
	end

	// timer output: inversion on matches, except match0 clears and duty match sets in RunMatchClr; one-shot set/reset by the two compares
	logic osOn, osOff;
	logic [15:0] loCmp, hiCmp;
	assign loCmp = (dutyCompareReg_q < periodCompareReg_q) ? dutyCompareReg_q
		: periodCompareReg_q;
	assign hiCmp = (dutyCompareReg_q < periodCompareReg_q) ? periodCompareReg_q
		: dutyCompareReg_q;
	assign osOn  = tick && mainCounter_q == loCmp;
	assign osOff = tick && mainCounter_q == hiCmp;
	always_ff @(posedge core_clk)
	begin
		if (srst || !running)
		begin
			timerOut_q <= 1'b0;
			osState_q  <= OsIdle;
		end
		else if (outCtrl_q[OcOneShot])
		begin
			if (clrStart)
				osState_q <= OsActive;
			else if (osState_q == OsActive && osOn)
				timerOut_q <= 1'b1;
			else if (osState_q == OsActive && osOff)
			begin
				timerOut_q <= 1'b0;
				osState_q  <= OsIdle;
			end
		end
		else if ((match0 && outCtrl_q[OcPerInv] && runMode_q == RunMatchClr)
			|| (matchN && outCtrl_q[OcDutyInv] && runMode_q == RunMatchClr))
			timerOut_q <= match0 ? 1'b0 : 1'b1;
		else if ((match0 && outCtrl_q[OcPerInv]) || (matchN && outCtrl_q[OcDutyInv]))
			timerOut_q <= !timerOut_q;
	end
	assign sharedPortPinOut = timerOut_q;
	assign sharedPortPinOeN = !outCtrl_q[OcOutEn];

	// read channel
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= RespOkay;
		end
		else if (rdFire)
		begin
			rvalid <= 1'b1;
			rresp  <= isMapped(araddr) ? RespOkay : RespSlvErr;
			unique case (araddr)
			OffCtrl:     rdata <= {29'h0, overflowFlag_q, runMode_q};
			OffPrescale: rdata <= {24'h0, prescalerModeReg_q};
			OffCapCtrl:  rdata <= {29'h0, capCtrl_q};
			OffOutCtrl:  rdata <= {25'h0, outCtrl_q};
			OffPeriod:   rdata <= {16'h0, periodCompareReg_q};
			OffDuty:     rdata <= {16'h0, dutyCompareReg_q};
			OffCount:    rdata <= {16'h0, mainCounter_q};
			OffStatus:   rdata <= {30'h0, flagN_q, flag0_q};
			default:     rdata <= 32'h0000_0000;
			endcase
		end
		else if (rready)
			rvalid <= 1'b0;
	end
endmodule : timer16_capture_compare

// ### testbench/timer16_assertions.sv
// Purpose: port-level checks for the capture/compare timer
// Assumes: one clock domain, srst synchronous active high
// Notes:   bound to every instance of the timer
`timescale 1ns/1ps
module timer16_assertions
	import timer16_pkg::*;
(
	// clock and reset
	input wire logic       core_clk,
	input wire logic       srst,
	// register bus
	input wire logic       awvalid,
	input wire logic       awready,
	input wire logic       wvalid,
	input wire logic       wready,
	input wire logic [1:0] bresp,
	input wire logic       bvalid,
	input wire logic       bready,
	input wire logic [7:0] araddr,
	input wire logic       arvalid,
	input wire logic       arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic       rvalid,
	input wire logic       rready,
	// pins and events
	input wire logic       sharedPortPinOeN,
	input wire logic       match0Irq,
	input wire logic       matchnIrq
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (srst);

	property p_rd_ans;
		arvalid && arready |=> rvalid;
	endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
	property p_wr_ans;
		awvalid && awready && wvalid && wready |=> bvalid;
	endproperty
	a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
	property p_r_hold;
		rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
	property p_b_hold;
		bvalid && !bready |=> bvalid && $stable(bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	property p_ar_rdy;
		arready == !rvalid;
	endproperty
	a_ar_rdy: assert property (p_ar_rdy) else $error("arready not inverse of rvalid");
	property p_bad_rd;
		arvalid && arready && (araddr > OffStatus || araddr[1:0] != 2'h0) |=> rresp == RespSlvErr;
	endproperty
	a_bad_rd: assert property (p_bad_rd) else $error("bad read not refused");
	property p_oe_cfg;
		$changed(sharedPortPinOeN) |-> bvalid || $past(bvalid);
	endproperty
	a_oe_cfg: assert property (p_oe_cfg) else $error("pin direction moved alone");
	property p_irq0_clr;
		$fell(match0Irq) |-> bvalid || $past(bvalid);
	endproperty
	a_irq0_clr: assert property (p_irq0_clr) else $error("match0 dropped alone");
	property p_irqn_clr;
		$fell(matchnIrq) |-> bvalid || $past(bvalid);
	endproperty
	a_irqn_clr: assert property (p_irqn_clr) else $error("matchn dropped alone");
endmodule : timer16_assertions

bind timer16_capture_compare timer16_assertions chk (.core_clk(core_clk), .srst(srst),
	.awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp),
	.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
	.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
	.sharedPortPinOeN(sharedPortPinOeN), .match0Irq(match0Irq), .matchnIrq(matchnIrq));

// ### testbench/pin_source_model.sv
// Purpose: external trigger sources and load on the timer output
// Assumes: pulses requested by the bench through pulse()
// Notes:   the shared pin carries the timer output when it is enabled
`timescale 1ns/1ps
module pin_source_model (
	// clock
	input wire logic core_clk,
	// shared pin
	input wire logic timerOut,
	input wire logic outEnN,
	output logic     pinLevel,
	// trigger 0
	output logic     trig0
);
	logic drive1 = 1'b0;
	initial trig0 = 1'b0;
	assign pinLevel = outEnN ? drive1 : timerOut;
	// each pulse is held and followed by a gap of width cycles
	task automatic pulse(input int sel, input int width);
		@(posedge core_clk);
		if (sel == 0) trig0 <= 1'b1;
		else drive1 <= 1'b1;
		repeat (width) @(posedge core_clk);
		trig0 <= 1'b0;
		drive1 <= 1'b0;
		repeat (width) @(posedge core_clk);
	endtask : pulse
endmodule : pin_source_model

// ### testbench/timer16_capture_compare_tb_top.sv
// Purpose: self-checking bench for the capture/compare timer
// Assumes: 100 MHz core clock, prescaler width 2
// Notes:   registers over AXI4-Lite, pins from the source model
`timescale 1ns/1ps
module timer16_capture_compare_tb_top;
	import timer16_pkg::*;
	logic        core_clk = 1'b0;
	logic        srst     = 1'b1;
	logic [7:0]  awaddr   = 8'h00;
	logic [7:0]  araddr   = 8'h00;
	logic [31:0] wdata    = 32'h0;
	logic        awvalid  = 1'b0;
	logic        wvalid   = 1'b0;
	logic        bready   = 1'b0;
	logic        arvalid  = 1'b0;
	logic        rready   = 1'b0;
	logic [3:0]  wstrb    = 4'hF;
	logic        awready, wready, bvalid, arready, rvalid, trig0, pinLv, pinOut, pinOeN, irq0;
	logic        irqN;
	logic [1:0]  bresp, rresp, rs, lastB;
	logic [31:0] rdata, rd, p, d, c1, c2;
	int          nFail = 0;
	int          numChecks = 0;
	int          hi, lo;

	initial forever #5 core_clk = ~core_clk;

	timer16_capture_compare #(.PrescaleW(2)) dut (.core_clk(core_clk), .srst(srst),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .triggerIn0(trig0), .sharedPortPinIn(pinLv),
		.sharedPortPinOut(pinOut), .sharedPortPinOeN(pinOeN), .match0Irq(irq0), .matchnIrq(irqN));
	pin_source_model src (.core_clk(core_clk), .timerOut(pinOut), .outEnN(pinOeN),
		.pinLevel(pinLv), .trig0(trig0));

	function automatic logic [31:0] ppg_len(input logic [31:0] v);
		return v + 32'h1;
	endfunction : ppg_len

	task automatic giveVerdict;
		$display("checks %0d failures %0d", numChecks, nFail);
		if (nFail == 0 && numChecks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : giveVerdict

	task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
		numChecks++;
		if (got !== exp)
		begin
			nFail++;
			$display("unexpected at %0t: %s got %0h want %0h", $time, what, got, exp);
		end
	endtask : check_val

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge core_clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge core_clk);
			awvalid <= awvalid & ~awready;
			wvalid <= wvalid & ~wready;
		end while ((awvalid & ~awready) | (wvalid & ~wready));
		do @(posedge core_clk); while (bvalid !== 1'b1);
		lastB = bresp;
		bready <= 1'b0;
	endtask : wr

	task automatic rd_reg(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge core_clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge core_clk); while (rvalid !== 1'b1);
		v = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd_reg

	task automatic count_lvl(input logic lvl, output int n);
		n = 0;
		while (pinOut === lvl && n < 600)
		begin
			@(posedge core_clk);
			n++;
		end
	endtask : count_lvl

	initial
	begin
		void'($urandom(32'hFC66FAD3));
		repeat (3) @(posedge core_clk);
		srst <= 1'b0;
		rd_reg(OffCtrl, rd, rs);
		check_val(rd, 32'h0, "ctrl after reset");
		rd_reg(8'h20, rd, rs);
		check_val(32'(rs), 32'(RespSlvErr), "unmapped read");
		for (int i = 0; i < 4; i++)
		begin
			p = $urandom_range(32'hFFFF, 0);
			wr(OffDuty, p);
			rd_reg(OffDuty, rd, rs);
			check_val(rd, p, "duty readback");
		end
		// a write without lane 0 and a misaligned write leave the duty alone
		wstrb <= 4'h0;
		wr(OffDuty, ~p);
		check_val(32'(lastB), 32'(RespOkay), "masked write answer");
		wstrb <= 4'hF;
		wr(8'h16, ~p);
		check_val(32'(lastB), 32'(RespSlvErr), "misaligned write answer");
		rd_reg(OffDuty, rd, rs);
		check_val(rd, p, "duty kept");
		wr(OffCtrl, 32'(RunFree));
		rd_reg(OffCount, c1, rs);
		rd_reg(OffCount, c2, rs);
		check_val(32'(c1 != c2), 32'h1, "counter runs");
		wr(OffCtrl, 32'(RunStop));
		rd_reg(OffCount, c1, rs);
		rd_reg(OffCount, c2, rs);
		check_val(c2, c1, "counter stopped");
		// event counting on trigger 0 rising edges
		wr(OffPrescale, 32'h13);
		wr(OffCtrl, 32'(RunFree));
		rd_reg(OffCount, c1, rs);
		src.pulse(0, 8);
		rd_reg(OffCount, c2, rs);
		check_val(c2, c1, "no count after first edge");
		repeat (4) src.pulse(0, 8);
		rd_reg(OffCount, c2, rs);
		check_val(c2 - c1, 32'(5 - EventStartN), "event count");
		wr(OffCtrl, 32'(RunStop));
		// pulse pattern in clear-on-match mode
		wr(OffPrescale, 32'h0);
		wr(OffOutCtrl, 32'h13);
		check_val(32'(pinOeN), 32'h0, "pin is output");
		for (int i = 0; i < 3; i++)
		begin
			p = $urandom_range(40, 8);
			d = (i == 0) ? 32'h1 : $urandom_range(p - 1, 1);
			wr(OffPeriod, p);
			wr(OffDuty, d);
			wr(OffCtrl, 32'(RunMatchClr));
			count_lvl(1'b1, hi);
			count_lvl(1'b0, lo);
			count_lvl(1'b1, hi);
			count_lvl(1'b0, lo);
			check_val(32'(hi + lo), ppg_len(p), "pattern cycle");
			check_val(32'(hi == ppg_len(d) || lo == ppg_len(d)), 32'h1, "active part");
			wr(OffCtrl, 32'(RunStop));
		end
		check_val(32'(irqN), 32'h1, "duty match request held");
		// duty rewrite while counting, by the safe sequence
		wr(OffCtrl, 32'(RunMatchClr));
		wr(OffOutCtrl, 32'h31);
		d = $urandom_range(p - 1, 1);
		wr(OffDuty, d);
		repeat (2) @(posedge core_clk);
		wr(OffOutCtrl, 32'h33);
		wr(OffStatus, 32'h1);
		wr(OffOutCtrl, 32'h13);
		count_lvl(1'b1, hi);
		count_lvl(1'b0, lo);
		count_lvl(1'b1, hi);
		count_lvl(1'b0, lo);
		check_val(32'(lo), ppg_len(d), "rewritten duty");
		check_val(32'(hi + lo), ppg_len(p), "cycle kept");
		wr(OffCtrl, 32'(RunStop));
		// input 1 edge with source select set
		wr(OffOutCtrl, 32'h0);
		wr(OffCapCtrl, 32'h3);
		wr(OffPrescale, 32'h40);
		p = $urandom_range(32'hFFFF, 0);
		wr(OffPeriod, p);
		wr(OffStatus, 32'h3);
		wr(OffCtrl, 32'(RunFree));
		src.pulse(1, 8);
		check_val(32'(irq0), 32'h1, "match0 on input 1");
		rd_reg(OffPeriod, rd, rs);
		check_val(rd, p, "period not captured");
		wr(OffStatus, 32'h1);
		repeat (2) @(posedge core_clk);
		check_val(32'(irq0), 32'h0, "match0 cleared");
		wr(OffCtrl, 32'(RunStop));
		// one-shot from a rising edge of trigger 0: high from duty to period count
		wr(OffCapCtrl, 32'h0);
		d = $urandom_range(20, 10);
		p = d + $urandom_range(30, 1);
		wr(OffDuty, d);
		wr(OffPeriod, p);
		wr(OffPrescale, 32'h10);
		wr(OffOutCtrl, 32'h14);
		wr(OffCtrl, 32'(RunFree));
		src.pulse(0, 3);
		count_lvl(1'b0, lo);
		count_lvl(1'b1, hi);
		check_val(32'(hi), p - d, "one-shot width");
		wr(OffCtrl, 32'(RunStop));
		wr(OffOutCtrl, 32'h0);
		// overflow with period at its top value
		wr(OffCapCtrl, 32'h0);
		wr(OffPrescale, 32'h0);
		wr(OffPeriod, 32'(CountMax));
		wr(OffCtrl, 32'(RunFree));
		rd = 32'h0;
		for (int k = 0; k < 30000 && rd[CtlOvf] !== 1'b1; k++)
			rd_reg(OffCtrl, rd, rs);
		check_val(32'(rd[CtlOvf]), 32'h1, "overflow set");
		rd_reg(OffCtrl, rd, rs);
		check_val(32'(rd[CtlOvf]), 32'h1, "overflow held");
		wr(OffCtrl, 32'(RunFree));
		rd_reg(OffCtrl, rd, rs);
		check_val(32'(rd[CtlOvf]), 32'h0, "overflow cleared");
		giveVerdict;
	end

	initial
	begin
		repeat (90000) @(posedge core_clk);
		nFail++;
		$display("unexpected at %0t: run timed out", $time);
		giveVerdict;
	end
endmodule : timer16_capture_compare_tb_top
